// ===== core/dual_port_block_ram.sv
// dual-port block memory top: port control, polarity options and wishbone registers
// Functional notes
// - each port acts on its own clock edge
// - disabled port does nothing, output holds
// - write stores word and mirrors it out
// - read drives addressed word in one edge
// - output reset zeroes output, array untouched; here a write on the same edge still stores its word
// - output shows last enabled access until next
// - data buses as wide as port width
// - clock, enable, write, reset polarity each selectable
// - one shared array, address times width mapping; here the width is rounded up to a power of two
// - widths 1 to 16, address bits shrink
// - double write to cell gives invalid contents; here port b's word is kept
// - read during other write returns invalid data; here the old word is returned
// - clash only on shared cell with write
// - other port output unchanged by a write
// - sixteen 256-bit init values load the array
// - unset or short init values zero padded
// - init value k fills bits 256k upward
//
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module dual_port_block_ram #(
   parameter int WIDTH_A = 16,
   parameter int WIDTH_B = 16,
   parameter dpram_pkg::init_table_t INIT_VALUES = '0,
   parameter logic [7:0] CONFIG_INIT = dpram_pkg::CONFIG_RESET
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // first port
   input wire logic clk_port_a,
   input wire logic en_a,
   input wire logic we_a,
   input wire logic out_rst_a,
   input wire logic [dpram_pkg::ARRAY_ADDR_BITS-$clog2(WIDTH_A)-1:0] addr_a,
   input wire logic [WIDTH_A-1:0] write_word_a,
   output logic [WIDTH_A-1:0] read_word_first_port,
   // second port
   input wire logic clk_port_b,
   input wire logic en_b,
   input wire logic we_b,
   input wire logic out_rst_b,
   input wire logic [dpram_pkg::ARRAY_ADDR_BITS-$clog2(WIDTH_B)-1:0] addr_b,
   input wire logic [WIDTH_B-1:0] write_word_b,
   output logic [WIDTH_B-1:0] read_word_second_port
);
   import dpram_pkg::*;

   logic [INV_BITS-1:0] inv_reg;
   logic [INV_BITS-1:0] inv_next;
   logic [STATUS_BITS-1:0] status_reg;
   logic [STATUS_BITS-1:0] status_next;
   logic [STATUS_BITS-1:0] clash_set;
   logic [31:0] dat_reg;
   logic [31:0] dat_next;
   logic ack_reg;
   logic ack_next;
   logic [1:0] pclk_prev_reg;
   logic [1:0] pclk_prev_next;
   logic [1:0] pclk_now;
   logic [1:0] port_edge;
   logic wr_commit;

   ram_access_if #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B)) ram_bus ();

   dpram_array #(
      .WIDTH_A(WIDTH_A),
      .WIDTH_B(WIDTH_B),
      .INIT_VALUES(INIT_VALUES)
   ) u_array (
      .clk(clk),
      .rst(rst),
      .port(ram_bus.mem)
   );

   // port clocks sampled on clk; the active edge is a rise after optional inversion
   always_comb begin
      pclk_now[0] = clk_port_a ^ inv_reg[INV_CLK_A_BIT];
      pclk_now[1] = clk_port_b ^ inv_reg[INV_CLK_B_BIT];
      pclk_prev_next = pclk_now;
      port_edge = pclk_now & ~pclk_prev_reg;
   end

   // each port sees only its own edge and inputs, no arbitration
   always_comb begin
      ram_bus.stb_a = port_edge[0] && (en_a ^ inv_reg[INV_EN_A_BIT]);
      ram_bus.we_a = we_a ^ inv_reg[INV_WE_A_BIT];
      ram_bus.srst_a = out_rst_a ^ inv_reg[INV_RST_A_BIT];
      ram_bus.addr_a = addr_a;
      ram_bus.din_a = write_word_a;
      ram_bus.stb_b = port_edge[1] && (en_b ^ inv_reg[INV_EN_B_BIT]);
      ram_bus.we_b = we_b ^ inv_reg[INV_WE_B_BIT];
      ram_bus.srst_b = out_rst_b ^ inv_reg[INV_RST_B_BIT];
      ram_bus.addr_b = addr_b;
      ram_bus.din_b = write_word_b;
   end

   // wishbone: ack one cycle after the request, write lands on the ack edge
   always_comb begin
      ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
      wr_commit = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
      dat_next = dat_reg;
      if (ack_next) begin
         case (wb_adr_i)
            CONFIG_OFFSET: dat_next = {24'h000000, inv_reg};
            STATUS_OFFSET: dat_next = {30'h00000000, status_reg};
            default: dat_next = 32'h00000000;
         endcase
      end
      inv_next = inv_reg;
      if (wr_commit && wb_adr_i == CONFIG_OFFSET && wb_sel_i[0]) begin
         inv_next = wb_dat_i[INV_BITS-1:0];
      end
   end

   // sticky clash flags, write one to clear, a new clash wins over the clear
   always_comb begin
      clash_set = '0;
      clash_set[CLASH_WW_BIT] = ram_bus.clash_ww;
      clash_set[CLASH_WR_BIT] = ram_bus.clash_wr;
      status_next = status_reg;
      if (wr_commit && wb_adr_i == STATUS_OFFSET && wb_sel_i[0]) begin
         status_next = status_reg & ~wb_dat_i[STATUS_BITS-1:0];
      end
      status_next = status_next | clash_set;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         inv_reg <= CONFIG_INIT;
         status_reg <= STATUS_RESET;
         dat_reg <= 32'h00000000;
         ack_reg <= 1'b0;
         pclk_prev_reg <= 2'h3;
      end else begin
         inv_reg <= inv_next;
         status_reg <= status_next;
         dat_reg <= dat_next;
         ack_reg <= ack_next;
         pclk_prev_reg <= pclk_prev_next;
      end
   end

   assign wb_dat_o = dat_reg;
   assign wb_ack_o = ack_reg;
   assign read_word_first_port = ram_bus.dout_a;
   assign read_word_second_port = ram_bus.dout_b;
endmodule

// ===== include/dpram_pkg.sv
// shared constants and types for the dual-port block memory
package dpram_pkg;
   // array geometry
   localparam int ARRAY_BITS = 4096;
   localparam int ARRAY_ADDR_BITS = 12;
   localparam int MAX_PORT_WIDTH = 16;
   localparam int INIT_COUNT = 16;
   localparam int INIT_BITS = 256;

   typedef logic [INIT_COUNT-1:0][INIT_BITS-1:0] init_table_t;
   typedef logic [ARRAY_BITS-1:0] array_t;

   // register map, byte addresses
   localparam logic [7:0] CONFIG_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;

   // config register fields: polarity inversion per control input
   localparam int INV_CLK_A_BIT = 0;
   localparam int INV_EN_A_BIT = 1;
   localparam int INV_WE_A_BIT = 2;
   localparam int INV_RST_A_BIT = 3;
   localparam int INV_CLK_B_BIT = 4;
   localparam int INV_EN_B_BIT = 5;
   localparam int INV_WE_B_BIT = 6;
   localparam int INV_RST_B_BIT = 7;
   localparam int INV_BITS = 8;
   localparam logic [7:0] CONFIG_RESET = 8'h00;

   // status register fields: sticky cross-port clash flags
   localparam int CLASH_WW_BIT = 0;
   localparam int CLASH_WR_BIT = 1;
   localparam int STATUS_BITS = 2;
   localparam logic [1:0] STATUS_RESET = 2'h0;
endpackage

// ===== include/ram_access_if.sv
// port strobes and data between the port control logic and the memory array
`timescale 1ns/1ps
interface ram_access_if #(
   parameter int WIDTH_A = 16,
   parameter int WIDTH_B = 16
);
   localparam int AW_A = dpram_pkg::ARRAY_ADDR_BITS - $clog2(WIDTH_A);
   localparam int AW_B = dpram_pkg::ARRAY_ADDR_BITS - $clog2(WIDTH_B);

   logic stb_a;
   logic we_a;
   logic srst_a;
   logic [AW_A-1:0] addr_a;
   logic [WIDTH_A-1:0] din_a;
   logic [WIDTH_A-1:0] dout_a;
   logic stb_b;
   logic we_b;
   logic srst_b;
   logic [AW_B-1:0] addr_b;
   logic [WIDTH_B-1:0] din_b;
   logic [WIDTH_B-1:0] dout_b;
   logic clash_ww;
   logic clash_wr;

   modport ctrl (
      output stb_a, we_a, srst_a, addr_a, din_a,
      output stb_b, we_b, srst_b, addr_b, din_b,
      input dout_a, dout_b, clash_ww, clash_wr
   );
   modport mem (
      input stb_a, we_a, srst_a, addr_a, din_a,
      input stb_b, we_b, srst_b, addr_b, din_b,
      output dout_a, dout_b, clash_ww, clash_wr
   );
endinterface

// ===== core/dpram_array.sv
// shared 4096-bit array with two width-configurable ports and registered outputs
`timescale 1ns/1ps
module dpram_array #(
   parameter int WIDTH_A = 16,
   parameter int WIDTH_B = 16,
   parameter dpram_pkg::init_table_t INIT_VALUES = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // port side
   ram_access_if.mem port
);
   import dpram_pkg::*;

   localparam int LG_A = $clog2(WIDTH_A);
   localparam int LG_B = $clog2(WIDTH_B);
   localparam array_t ARRAY_RESET = array_t'(INIT_VALUES);

   array_t mem_reg;
   array_t mem_next;
   logic [WIDTH_A-1:0] dout_a_reg;
   logic [WIDTH_A-1:0] dout_a_next;
   logic [WIDTH_B-1:0] dout_b_reg;
   logic [WIDTH_B-1:0] dout_b_next;
   logic [ARRAY_ADDR_BITS-1:0] base_a;
   logic [ARRAY_ADDR_BITS-1:0] base_b;
   logic hit;

   // first cell of a word: address times width rounded up to a power of two
   function automatic logic [ARRAY_ADDR_BITS-1:0] cell_base(
      input logic [ARRAY_ADDR_BITS-1:0] addr,
      input int unsigned lg
   );
      cell_base = ARRAY_ADDR_BITS'(addr << lg);
   endfunction

   // two cell ranges share at least one cell
   function automatic logic ranges_overlap(
      input logic [ARRAY_ADDR_BITS:0] sa,
      input logic [ARRAY_ADDR_BITS:0] wa,
      input logic [ARRAY_ADDR_BITS:0] sb,
      input logic [ARRAY_ADDR_BITS:0] wb
   );
      ranges_overlap = (sa < sb + wb) && (sb < sa + wa);
   endfunction

   always_comb begin
      base_a = cell_base(ARRAY_ADDR_BITS'(port.addr_a), LG_A);
      base_b = cell_base(ARRAY_ADDR_BITS'(port.addr_b), LG_B);
      mem_next = mem_reg;
      dout_a_next = dout_a_reg;
      dout_b_next = dout_b_reg;
      if (port.stb_a) begin
         if (port.we_a) begin
            mem_next[base_a +: WIDTH_A] = port.din_a;
            dout_a_next = port.din_a;
         end else begin
            dout_a_next = mem_reg[base_a +: WIDTH_A];
         end
         if (port.srst_a) begin
            dout_a_next = '0;
         end
      end
      // port b applied last: on a same-cell double write its word is kept
      if (port.stb_b) begin
         if (port.we_b) begin
            mem_next[base_b +: WIDTH_B] = port.din_b;
            dout_b_next = port.din_b;
         end else begin
            dout_b_next = mem_reg[base_b +: WIDTH_B];
         end
         if (port.srst_b) begin
            dout_b_next = '0;
         end
      end
   end

   // clash only when both ports touch a shared cell and one writes
   always_comb begin
      hit = port.stb_a && port.stb_b &&
         ranges_overlap({1'b0, base_a}, (ARRAY_ADDR_BITS+1)'(WIDTH_A),
                        {1'b0, base_b}, (ARRAY_ADDR_BITS+1)'(WIDTH_B));
      port.clash_ww = hit && port.we_a && port.we_b;
      port.clash_wr = hit && (port.we_a ^ port.we_b);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_reg <= ARRAY_RESET;
         dout_a_reg <= '0;
         dout_b_reg <= '0;
      end else begin
         mem_reg <= mem_next;
         dout_a_reg <= dout_a_next;
         dout_b_reg <= dout_b_next;
      end
   end

   assign port.dout_a = dout_a_reg;
   assign port.dout_b = dout_b_reg;
endmodule

// ===== sim/ram_checker_sva.sv
// port-level assertions for the dual-port block memory
`timescale 1ns/1ps
module ram_checker #(parameter int WIDTH_A = 16, parameter int WIDTH_B = 16) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // first port
   input wire logic clk_port_a,
   input wire logic en_a,
   input wire logic we_a,
   input wire logic out_rst_a,
   input wire logic [WIDTH_A-1:0] write_word_a,
   input wire logic [WIDTH_A-1:0] read_word_first_port,
   // second port
   input wire logic clk_port_b,
   input wire logic [WIDTH_B-1:0] read_word_second_port
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   unmapped_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
      && wb_adr_i != 8'h00 && wb_adr_i != 8'h04 |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   write_mirror_a: assert property ($rose(clk_port_a) && en_a && we_a && !out_rst_a
      |=> read_word_first_port == $past(write_word_a)) else $error("write not mirrored");
   out_clear_a: assert property ($rose(clk_port_a) && en_a && out_rst_a
      |=> read_word_first_port == '0) else $error("output reset did not clear");
   disabled_hold_a: assert property ($rose(clk_port_a) && !en_a
      |=> $stable(read_word_first_port)) else $error("disabled port changed output");
   first_hold_a: assert property (clk_port_a == $past(clk_port_a)
      |=> $stable(read_word_first_port)) else $error("first output moved without edge");
   second_hold_a: assert property (clk_port_b == $past(clk_port_b)
      |=> $stable(read_word_second_port)) else $error("second output moved without edge");
   cover property (wb_ack_o && wb_we_i);
   cover property ($rose(clk_port_a) && en_a && we_a);
   cover property ($rose(clk_port_a) && en_a && out_rst_a && we_a);
endmodule
bind dual_port_block_ram ram_checker #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B)) u_ram_checker (
   .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
   .clk_port_a, .en_a, .we_a, .out_rst_a, .write_word_a, .read_word_first_port,
   .clk_port_b, .read_word_second_port);

// ===== sim/fabric_port.sv
// user fabric model driving one memory port
`timescale 1ns/1ps
module fabric_port #(parameter int W = 16, parameter int AW = 8) (
   // system clock
   input wire logic clk,
   // port drive
   output logic pclk,
   output logic en,
   output logic we,
   output logic orst,
   output logic [AW-1:0] addr,
   output logic [W-1:0] wd
);
   initial begin
      {pclk, en, we, orst, addr, wd} = '0;
   end
   // one port edge; afterwards the port clock rests low and released lines carry junk
   task automatic access(input logic e, w, r, input logic [AW-1:0] a, input logic [W-1:0] d);
      @(posedge clk);
      {pclk, en, we, orst, addr, wd} <= {1'b1, e, w, r, a, d};
      @(posedge clk);
      {pclk, en, we, orst} <= 4'h0;
      addr <= ~a;
      wd <= ~d;
      @(posedge clk);
   endtask
endmodule

// ===== sim/tb_dual_port_block_ram.sv
// self-checking bench for the dual-port block memory
`timescale 1ns/1ps
module tb_dual_port_block_ram;
   import dpram_pkg::*;
   localparam init_table_t INITS = init_table_t'(4096'h1234) << 256;
   typedef struct packed {logic w; logic [7:0] a; logic [15:0] d; logic [15:0] e;} row_t;
   row_t rows [6] = '{'{1, 8'h03, 16'h5A5A, 16'h5A5A}, '{1, 8'hFF, 16'hC3A5, 16'hC3A5},
      '{0, 8'h03, 16'h0, 16'h5A5A}, '{0, 8'h10, 16'h0, 16'h1234},
      '{0, 8'h00, 16'h0, 16'h0}, '{0, 8'hFF, 16'h0, 16'hC3A5}};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, wwe = 1'b0, ack;
   logic [7:0] adr = 8'h0;
   logic [3:0] sel = 4'h0;
   logic [31:0] dw = 32'h0, dr, q;
   logic pca, ena, wea, ora, pcb, enb, web, orb;
   logic [7:0] aa, wdb;
   logic [8:0] ab;
   logic [15:0] wa, qa;
   logic [7:0] qb;
   int num_errors = 0, n_compared = 0, cycles = 0;
   always #20 clk = ~clk;
   dual_port_block_ram #(.WIDTH_A(16), .WIDTH_B(8), .INIT_VALUES(INITS)) u_dual_port_block_ram (
      .clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .clk_port_a(pca),
      .en_a(ena), .we_a(wea), .out_rst_a(ora), .addr_a(aa), .write_word_a(wa),
      .read_word_first_port(qa), .clk_port_b(pcb), .en_b(enb), .we_b(web), .out_rst_b(orb),
      .addr_b(ab), .write_word_b(wdb), .read_word_second_port(qb));
   fabric_port #(.W(16), .AW(8)) u_fabric_port_a (.clk, .pclk(pca), .en(ena), .we(wea),
      .orst(ora), .addr(aa), .wd(wa));
   fabric_port #(.W(8), .AW(9)) u_fabric_port_b (.clk, .pclk(pcb), .en(enb), .we(web),
      .orst(orb), .addr(ab), .wd(wdb));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s = 4'hF);
      @(posedge clk);
      {cyc, stb, wwe, adr, dw, sel} <= {2'b11, w, a, d, s};
      do @(posedge clk); while (ack !== 1'b1);
      q = dr;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic complete_run;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         num_errors++;
         complete_run();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk({ack, 15'h0, qa}, 32'h0);
      foreach (rows[i]) begin
         u_fabric_port_a.access(1'b1, rows[i].w, 1'b0, rows[i].a, rows[i].d);
         #1;
         chk(32'(qa), 32'(rows[i].e));
      end
      u_fabric_port_b.access(1'b1, 1'b0, 1'b0, 9'h1FE, 8'h00);
      #1;
      chk(32'(qb), 32'hA5);
      u_fabric_port_a.access(1'b1, 1'b1, 1'b0, 8'hFF, 16'h0F0F);
      #1;
      chk(32'(qb), 32'hA5);
      u_fabric_port_b.access(1'b1, 1'b0, 1'b0, 9'h1FE, 8'h00);
      #1;
      chk(32'(qb), 32'h0F);
      u_fabric_port_a.access(1'b0, 1'b1, 1'b0, 8'h03, 16'h1111);
      #1;
      chk(32'(qa), 32'h0F0F);
      u_fabric_port_a.access(1'b1, 1'b1, 1'b1, 8'h03, 16'h2222);
      #1;
      chk(32'(qa), 32'h0);
      u_fabric_port_a.access(1'b1, 1'b0, 1'b0, 8'h03, 16'h0);
      #1;
      chk(32'(qa), 32'h2222);
      bus(1'b0, CONFIG_OFFSET, 32'h0);
      chk(q, 32'(CONFIG_RESET));
      bus(1'b0, 8'h08, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, CONFIG_OFFSET, 32'(1 << INV_EN_B_BIT));
      u_fabric_port_b.access(1'b0, 1'b0, 1'b0, 9'h006, 8'h00);
      #1;
      chk(32'(qb), 32'h22);
      bus(1'b1, CONFIG_OFFSET, 32'h0);
      fork
         u_fabric_port_a.access(1'b1, 1'b1, 1'b0, 8'h00, 16'hAAAA);
         u_fabric_port_b.access(1'b1, 1'b1, 1'b0, 9'h001, 8'h55);
      join
      #1;
      chk({qa, 8'h0, qb}, 32'hAAAA0055);
      bus(1'b0, STATUS_OFFSET, 32'h0);
      chk(q, 32'(1 << CLASH_WW_BIT));
      bus(1'b1, STATUS_OFFSET, 32'h3);
      fork
         u_fabric_port_a.access(1'b1, 1'b1, 1'b0, 8'h01, 16'h7777);
         u_fabric_port_b.access(1'b1, 1'b0, 1'b0, 9'h000, 8'h00);
      join
      bus(1'b0, STATUS_OFFSET, 32'h0);
      chk(q, 32'h0);
      fork
         u_fabric_port_a.access(1'b1, 1'b1, 1'b0, 8'h00, 16'hBBBB);
         u_fabric_port_b.access(1'b1, 1'b0, 1'b0, 9'h000, 8'h00);
      join
      #1;
      chk(32'(qa), 32'hBBBB);
      bus(1'b0, STATUS_OFFSET, 32'h0);
      chk(q, 32'(1 << CLASH_WR_BIT));
      // a write with byte lane 0 off must be dropped
      bus(1'b1, CONFIG_OFFSET, 32'h000000FF, 4'h0);
      bus(1'b0, CONFIG_OFFSET, 32'h0);
      chk(q, 32'(CONFIG_RESET));
      bus(1'b1, CONFIG_OFFSET, 32'((1 << INV_WE_B_BIT) | (1 << INV_RST_B_BIT)));
      u_fabric_port_b.access(1'b1, 1'b0, 1'b1, 9'h006, 8'h66);
      #1;
      chk(32'(qb), 32'h66);
      u_fabric_port_b.access(1'b1, 1'b1, 1'b0, 9'h006, 8'h00);
      #1;
      chk(32'(qb), 32'h0);
      bus(1'b1, CONFIG_OFFSET, 32'h0);
      u_fabric_port_a.access(1'b1, 1'b0, 1'b0, 8'h03, 16'h0);
      #1;
      chk(32'(qa), 32'h2266);
      // second reset in mid-run: outputs, status and array contents come back
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk({ack, 15'h0, qa}, 32'h0);
      bus(1'b0, STATUS_OFFSET, 32'h0);
      chk(q, 32'(STATUS_RESET));
      u_fabric_port_a.access(1'b1, 1'b0, 1'b0, 8'h00, 16'h0);
      #1;
      chk(32'(qa), 32'h0);
      u_fabric_port_a.access(1'b1, 1'b0, 1'b0, 8'h10, 16'h0);
      #1;
      chk(32'(qa), 32'h1234);
      complete_run();
   end
endmodule
